// ===== rtl/nor_host_pkg.sv
// package for the parallel nor flash host controller
// How it works
// - commands sent as plain write cycles
// - start by sequence, poll status and ready
// - bypass mode programs in two writes
package nor_host_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [11:0] UNLOCK_A1 = 12'h0_555;
  localparam logic [11:0] UNLOCK_A2 = 12'h0_2AA;
  localparam logic [7:0] UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SECURE = 8'h88;
  localparam logic [7:0] CMD_SEC_EXIT = 8'h90;
  localparam int DATA_POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int CYCLE_NS = 5;
  localparam int T_ACC_NS = 90;
  localparam int T_PAGE_NS = 25;
  localparam int T_WP_NS = 35;
  localparam int T_RST_NS = 500;
  localparam int ACC_CYC = (T_ACC_NS + CYCLE_NS - 1) / CYCLE_NS;
  localparam int PAGE_CYC = (T_PAGE_NS + CYCLE_NS - 1) / CYCLE_NS;
  localparam int WP_CYC = (T_WP_NS + CYCLE_NS - 1) / CYCLE_NS;
  localparam int RST_CYC = (T_RST_NS + CYCLE_NS - 1) / CYCLE_NS;
  localparam int PAGE_WORDS = 8;
  localparam int BUF_WORDS = 16;
  localparam int SEQ_MAX = 6;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROG = 3'h1,
    OP_ERASE = 3'h2,
    OP_SUSPEND = 3'h3,
    OP_RESUME = 3'h4,
    OP_BYPASS = 3'h5,
    OP_SECURE = 3'h6,
    OP_ABORT = 3'h7
  } op_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_word_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic byte_n;
  } ctl_t;
endpackage

// ===== rtl/seq_rom.sv
// command sequence table: address/data of each write step
`timescale 1ns/1ps
module seq_rom
  import nor_host_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire op_t               op_i,
  input  wire logic              bypass_i,
  input  wire logic [2:0]        step_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic [2:0]             len_o,
  output bus_word_t              word_o
);
  bus_word_t w;
  logic [2:0] len;
  function automatic bus_word_t cw(input logic [11:0] a, input logic [7:0] d);
    bus_word_t r;
    r.addr = {{(ADDR_W-12){1'b0}}, a};
    r.data = {8'h00, d};
    return r;
  endfunction
  always_comb begin
    len = 3'd1;
    w = cw(UNLOCK_A1, CMD_RESET);
    unique case (op_i)
      OP_PROG: begin
        if (bypass_i) begin
          len = 3'd2;
          w = (step_i == 3'd0) ? cw(UNLOCK_A1, CMD_PROG) : bus_word_t'{addr_i, data_i};
        end else begin
          len = 3'd4;
          unique case (step_i)
            3'd0: w = cw(UNLOCK_A1, UNLOCK_D1);
            3'd1: w = cw(UNLOCK_A2, UNLOCK_D2);
            3'd2: w = cw(UNLOCK_A1, CMD_PROG);
            default: w = bus_word_t'{addr_i, data_i};
          endcase
        end
      end
      OP_ERASE: begin
        len = 3'd6;
        unique case (step_i)
          3'd0, 3'd3: w = cw(UNLOCK_A1, UNLOCK_D1);
          3'd1, 3'd4: w = cw(UNLOCK_A2, UNLOCK_D2);
          3'd2: w = cw(UNLOCK_A1, CMD_ERASE);
          default: w = bus_word_t'{addr_i, {8'h00, CMD_SECTOR}};
        endcase
      end
      OP_SUSPEND: w = bus_word_t'{addr_i, {8'h00, CMD_SUSPEND}};
      OP_RESUME: w = bus_word_t'{addr_i, {8'h00, CMD_RESUME}};
      OP_BYPASS, OP_SECURE: begin
        len = 3'd3;
        unique case (step_i)
          3'd0: w = cw(UNLOCK_A1, UNLOCK_D1);
          3'd1: w = cw(UNLOCK_A2, UNLOCK_D2);
          default: w = cw(UNLOCK_A1, (op_i == OP_BYPASS) ? CMD_BYPASS : CMD_SECURE);
        endcase
      end
      default: begin
        len = 3'd1;
        w = cw(UNLOCK_A1, CMD_RESET);
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    word_o <= w;
    len_o <= len;
  end
endmodule

// ===== rtl/nor_flash_host.sv
// host controller driving a parallel nor flash through its pins
`timescale 1ns/1ps
module nor_flash_host
  import nor_host_pkg::*;
#(
  parameter int AW = ADDR_W
)(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              req_valid_i,
  input  wire op_t               req_op_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_data_i,
  input  wire logic              byte_mode_i,
  input  wire logic              wp_enable_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   bypass_o,
  output logic                   busy_o,
  output logic [AW-1:0]          flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_n_o,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  output logic                   flash_reset_n_o,
  output logic                   flash_byte_n_o,
  output logic                   write_protect_accel_n_o,
  input  wire logic              ready_busy_n_i
);
  typedef enum logic [6:0] {
    S_RST   = 7'b000_0001,
    S_IDLE  = 7'b000_0010,
    S_LOAD  = 7'b000_0100,
    S_WRITE = 7'b000_1000,
    S_READ  = 7'b001_0000,
    S_POLL  = 7'b010_0000,
    S_DONE  = 7'b100_0000
  } st_t;

  st_t st_r, st_nxt;
  op_t op_r, op_nxt;
  logic [2:0] step_r, step_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] data_r, data_nxt, rdata_nxt;
  logic [DATA_W-1:0] last_r, last_nxt;
  logic bypass_r, bypass_nxt;
  logic first_r, first_nxt;
  bus_word_t word;
  logic [2:0] len;
  ctl_t ctl_r, ctl_nxt;
  logic [AW-1:0] fa_nxt;
  logic [DATA_W-1:0] fd_nxt;
  logic oe_n_nxt;

  // table word is registered, so every write step opens with one load cycle
  seq_rom u_seq (
    .mclk_i   (mclk_i),
    .op_i     (op_r),
    .bypass_i (bypass_r),
    .step_i   (step_r),
    .addr_i   (addr_r),
    .data_i   (data_r),
    .len_o    (len),
    .word_o   (word)
  );

  assign req_ready_o = (st_r == S_IDLE);
  assign busy_o = ~ready_busy_n_i;
  assign bypass_o = bypass_r;
  assign flash_ce_n_o = ctl_r.ce_n;
  assign flash_oe_n_o = ctl_r.oe_n;
  assign flash_we_n_o = ctl_r.we_n;
  assign flash_reset_n_o = ctl_r.reset_n;
  assign flash_byte_n_o = ctl_r.byte_n;
  assign write_protect_accel_n_o = ~wp_enable_i;

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    rdata_nxt = rdata_o;
    last_nxt = last_r;
    bypass_nxt = bypass_r;
    first_nxt = first_r;
    ctl_nxt = ctl_r;
    ctl_nxt.byte_n = ~byte_mode_i;
    fa_nxt = flash_addr_o;
    fd_nxt = flash_dq_o;
    oe_n_nxt = 1'b1;
    done_o = 1'b0;
    unique case (st_r)
      // reset pulse also clears bypass, since the flash forgets it too
      S_RST: begin
        ctl_nxt.reset_n = 1'b0;
        ctl_nxt.ce_n = 1'b1;
        ctl_nxt.oe_n = 1'b1;
        ctl_nxt.we_n = 1'b1;
        bypass_nxt = 1'b0;
        cnt_nxt = cnt_r + 8'd1;
        if (cnt_r == 8'(RST_CYC)) begin
          ctl_nxt.reset_n = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      // suspend and resume only leave idle: program and erase are polled
      // to their end here, so a suspend never breaks into a running op
      S_IDLE: begin
        ctl_nxt.ce_n = 1'b1;
        if (req_valid_i) begin
          op_nxt = req_op_i;
          addr_nxt = req_addr_i;
          data_nxt = req_data_i;
          step_nxt = 3'd0;
          cnt_nxt = 8'd0;
          if (req_op_i == OP_ABORT) st_nxt = S_RST;
          else if (req_op_i == OP_READ) st_nxt = S_READ;
          else st_nxt = S_LOAD;
        end
      end
      S_LOAD: st_nxt = S_WRITE; // table output is registered
      S_WRITE: begin
        fa_nxt = word.addr[AW-1:0];
        fd_nxt = word.data;
        oe_n_nxt = 1'b0;
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.we_n = (cnt_r < 8'(WP_CYC)) ? 1'b0 : 1'b1;
        cnt_nxt = cnt_r + 8'd1;
        if (cnt_r == 8'(2 * WP_CYC)) begin
          cnt_nxt = 8'd0;
          ctl_nxt.ce_n = 1'b1;
          if (step_r == len - 3'd1) begin
            if (op_r == OP_BYPASS) bypass_nxt = 1'b1;
            if (op_r == OP_PROG || op_r == OP_ERASE) begin
              first_nxt = 1'b1;
              st_nxt = S_POLL;
            end else st_nxt = S_DONE;
          end else begin
            step_nxt = step_r + 3'd1;
            st_nxt = S_LOAD;
          end
        end
      end
      S_READ: begin
        fa_nxt = addr_r[AW-1:0];
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.oe_n = 1'b0;
        cnt_nxt = cnt_r + 8'd1;
        if (cnt_r == 8'(ACC_CYC)) begin
          rdata_nxt = flash_dq_i;
          ctl_nxt.ce_n = 1'b1;
          ctl_nxt.oe_n = 1'b1;
          st_nxt = S_DONE;
        end
      end
      S_POLL: begin
        fa_nxt = addr_r[AW-1:0];
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.oe_n = 1'b0;
        cnt_nxt = cnt_r + 8'd1;
        if (cnt_r == 8'(ACC_CYC)) begin
          cnt_nxt = 8'd0;
          ctl_nxt.oe_n = 1'b1;
          last_nxt = flash_dq_i;
          first_nxt = 1'b0;
          // stable toggle bit on two reads plus ready pin means finished
          if (!first_r && (flash_dq_i[TOGGLE_BIT] == last_r[TOGGLE_BIT]) && ready_busy_n_i) begin
            rdata_nxt = flash_dq_i;
            ctl_nxt.ce_n = 1'b1;
            st_nxt = S_DONE;
          end
        end
      end
      // one-cycle pulse; rdata_o already holds the answer
      S_DONE: begin
        done_o = 1'b1;
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_RST;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= S_RST;
      op_r <= OP_READ;
      step_r <= 3'd0;
      cnt_r <= 8'd0;
      addr_r <= '0;
      data_r <= '0;
      last_r <= '0;
      rdata_o <= '0;
      bypass_r <= 1'b0;
      first_r <= 1'b0;
      ctl_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0, byte_n: 1'b1};
      flash_addr_o <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_n_o <= 1'b1;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      last_r <= last_nxt;
      rdata_o <= rdata_nxt;
      bypass_r <= bypass_nxt;
      first_r <= first_nxt;
      ctl_r <= ctl_nxt;
      flash_addr_o <= fa_nxt;
      flash_dq_o <= fd_nxt;
      flash_dq_oe_n_o <= oe_n_nxt;
    end
  end
endmodule

// ===== tb/nor_flash_host_monitor.sv
// checker of host-side flash pin behaviour
`timescale 1ns/1ps
module nor_flash_host_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic byte_mode_i,
  input wire logic wp_enable_i,
  input wire logic busy_o,
  input wire logic ready_busy_n_i,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_dq_oe_n_o,
  input wire logic flash_reset_n_o,
  input wire logic flash_byte_n_o,
  input wire logic write_protect_accel_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_byte; !$past(rst_i) |-> flash_byte_n_o == !$past(byte_mode_i); endproperty
  a_byte: assert property (p_byte)
    else $error("byte pin not following mode");
  property p_wp; write_protect_accel_n_o == !wp_enable_i; endproperty
  a_wp: assert property (p_wp)
    else $error("protect pin wrong");
  property p_busy; busy_o == !ready_busy_n_i; endproperty
  a_busy: assert property (p_busy)
    else $error("busy not mirroring ready pin");
  property p_done; done_o |=> !done_o; endproperty
  a_done: assert property (p_done)
    else $error("done longer than one cycle");
  property p_done_rdy; done_o |-> ready_busy_n_i; endproperty
  a_done_rdy: assert property (p_done_rdy)
    else $error("done while flash busy");
  property p_no_rw; !(!flash_we_n_o && !flash_oe_n_o); endproperty
  a_no_rw: assert property (p_no_rw)
    else $error("read and write enables both low");
  property p_we_drv; !flash_we_n_o |-> !flash_ce_n_o && !flash_dq_oe_n_o; endproperty
  a_we_drv: assert property (p_we_drv)
    else $error("write strobe without select or data");
  property p_we_len; $fell(flash_we_n_o) |-> !flash_we_n_o [*7] ##1 flash_we_n_o; endproperty
  a_we_len: assert property (p_we_len)
    else $error("write pulse length wrong");
  property p_standby; req_ready_o |-> flash_ce_n_o; endproperty
  a_standby: assert property (p_standby)
    else $error("chip selected while idle");
  property p_rst; $fell(flash_reset_n_o) |-> !flash_reset_n_o [*8]; endproperty
  a_rst: assert property (p_rst)
    else $error("reset pulse too short");
endmodule
bind nor_flash_host nor_flash_host_monitor mon_u (.mclk_i, .rst_i, .req_ready_o, .done_o, .byte_mode_i,
  .wp_enable_i, .busy_o, .ready_busy_n_i, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_dq_oe_n_o,
  .flash_reset_n_o, .flash_byte_n_o, .write_protect_accel_n_o);

// ===== tb/nor_flash_model.sv
// behavioural parallel nor flash for the host bench
`timescale 1ns/1ps
module nor_flash_model #(parameter int BUSY = 60) (
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        reset_n_i,
  input  wire logic        wp_n_i,
  output logic      [15:0] dq_o,
  output logic             ready_busy_n_o
);
  logic [15:0] mem[int];
  logic [15:0] last = 16'h0000;
  logic [15:0] pd = 16'h0000;
  int cnt = 0;
  int q[$];
  bit susp, prog, ers, tog, sec;
  function automatic bit prot(logic [21:0] a);
    return !wp_n_i && a[21:15] == 7'h00;
  endfunction
  assign ready_busy_n_o = cnt == 0 || susp;
  always #5 if (cnt > 0 && !susp) cnt--;
  always @(negedge reset_n_i) begin
    cnt = 0; susp = 0; prog = 0; ers = 0; sec = 0;
  end
  always @(negedge oe_n_i) tog = !tog;
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i) begin
    if (prog) begin
      prog = 0;
      pd = dq_i;
      if (!prot(addr_i)) mem[addr_i] = dq_i;
      cnt = BUSY;
    end else if (dq_i[7:0] == 8'h30 && ers) begin
      ers = 0;
      q.delete();
      // sector index is the word address above the 32 Kword boundary
      foreach (mem[k]) if ((k >> 15) == (addr_i >> 15)) q.push_back(k);
      if (!prot(addr_i)) foreach (q[i]) mem.delete(q[i]);
      cnt = 4 * BUSY;
    end else if (dq_i[7:0] == 8'h30) susp = 0;
    else if (dq_i[7:0] == 8'hB0) susp = 1;
    else if (dq_i[7:0] == 8'hA0) prog = 1;
    else if (dq_i[7:0] == 8'h80) ers = 1;
    else if (dq_i[7:0] == 8'h88) sec = 1;
  end
  // released bus shows the inverse so a stale value never passes
  always #1 dq_o = (!ce_n_i && !oe_n_i && reset_n_i) ? ((cnt > 0 && !susp) ? {8'h00, !pd[7], tog, 6'h00} :
    (mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF)) : ~last;
  always @(posedge oe_n_i) last = dq_o;
endmodule

// ===== tb/test_parallel_nor_flash_control.sv
// self-checking bench for the nor flash host controller
`timescale 1ns/1ps
module test_parallel_nor_flash_control;
  import nor_host_pkg::*;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
  logic mclk_i = 0, rst_i = 1, req_valid_i = 0, byte_mode_i = 0, wp_enable_i = 0;
  op_t req_op_i = OP_READ;
  logic [ADDR_W-1:0] req_addr_i = '0, fa;
  logic [DATA_W-1:0] req_data_i = '0, rdata_o, dq_o, dq_i;
  logic req_ready_o, done_o, bypass_o, busy_o, dq_oe_n, ce_n, oe_n, we_n, reset_n, byte_n, wp_n, rb_n;
  int miscompares = 0, checks = 0, wes = 0, rsts = 0;
  nor_flash_host dut_u (.mclk_i, .rst_i, .req_valid_i, .req_op_i, .req_addr_i, .req_data_i, .byte_mode_i,
    .wp_enable_i, .req_ready_o, .done_o, .rdata_o, .bypass_o, .busy_o, .flash_addr_o(fa), .flash_dq_o(dq_o),
    .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_i), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
    .flash_reset_n_o(reset_n), .flash_byte_n_o(byte_n), .write_protect_accel_n_o(wp_n), .ready_busy_n_i(rb_n));
  nor_flash_model flash_u (.addr_i(fa), .dq_i(dq_o), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .reset_n_i(reset_n), .wp_n_i(wp_n), .dq_o(dq_i), .ready_busy_n_o(rb_n));
  initial forever #2.5 mclk_i = ~mclk_i;
  always @(negedge we_n) wes++;
  always @(negedge reset_n) rsts++;
  task automatic op(input op_t o, input logic [21:0] a, input logic [15:0] d);
    int n = 0;
    while (req_ready_o !== 1'b1 && n < 999) begin
      @(posedge mclk_i); #1;
      n++;
    end
    if (n >= 999) miscompares++;
    req_valid_i = 1; req_op_i = o; req_addr_i = a; req_data_i = d;
    @(posedge mclk_i); #1;
    req_valid_i = 0;
    n = 0;
    while (o != OP_ABORT && done_o !== 1'b1 && n < 4000) begin
      @(posedge mclk_i); #1;
      n++;
    end
    if (n >= 4000) miscompares++;
    @(posedge mclk_i); #1;
  endtask
  task automatic t_prog;
    wes = 0;
    op(OP_PROG, 22'h0_8010, 16'h1234);
    `CHK("writes", 4, wes)
    op(OP_READ, 22'h0_8010, 16'h0000);
    `CHK("rdata", 16'h1234, rdata_o)
    $display("done prog");
  endtask
  task automatic t_erase;
    op(OP_PROG, 22'h1_0000, 16'h5A5A);
    op(OP_ERASE, 22'h0_8000, 16'h0000);
    op(OP_READ, 22'h0_8010, 16'h0000);
    `CHK("erased", 16'hFFFF, rdata_o)
    op(OP_READ, 22'h1_0000, 16'h0000);
    `CHK("kept", 16'h5A5A, rdata_o)
    $display("done erase");
  endtask
  task automatic t_bypass;
    op(OP_BYPASS, 22'h0_0000, 16'h0000);
    `CHK("bypass", 1'b1, bypass_o)
    wes = 0;
    op(OP_PROG, 22'h0_8011, 16'hBEEF);
    `CHK("writes", 2, wes)
    $display("done bypass");
  endtask
  task automatic t_abort;
    rsts = 0;
    op(OP_ABORT, 22'h0_0000, 16'h0000);
    op(OP_READ, 22'h0_8011, 16'h0000);
    `CHK("resets", 1, rsts)
    `CHK("bypass", 1'b0, bypass_o)
    `CHK("rdata", 16'hBEEF, rdata_o)
    $display("done abort");
  endtask
  task automatic t_wp;
    wp_enable_i = 1;
    op(OP_PROG, 22'h0_0005, 16'h0F0F);
    `CHK("wp pin", 1'b0, wp_n)
    op(OP_READ, 22'h0_0005, 16'h0000);
    `CHK("guarded", 16'hFFFF, rdata_o)
    wp_enable_i = 0;
    $display("done wp");
  endtask
  task automatic t_byte;
    byte_mode_i = 1;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK("byte pin", 1'b0, byte_n)
    byte_mode_i = 0;
    $display("done byte");
  endtask
  task automatic t_cmds;
    wes = 0;
    op(OP_SUSPEND, 22'h0_8000, 16'h0000);
    `CHK("suspended", 1'b1, flash_u.susp)
    op(OP_RESUME, 22'h0_8000, 16'h0000);
    `CHK("resumed", 1'b0, flash_u.susp)
    `CHK("writes", 2, wes)
    wes = 0;
    op(OP_SECURE, 22'h0_0000, 16'h0000);
    `CHK("writes", 3, wes)
    `CHK("secure", 1'b1, flash_u.sec)
    $display("done cmds");
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    #1 rst_i = 0;
    t_prog();
    t_erase();
    t_bypass();
    t_abort();
    t_wp();
    t_byte();
    t_cmds();
    test_done;
  end
endmodule
